// ===== hbis_homing_seq.v
// homing sequencer: index, current position and hard-stop methods
`include "hbis_defs.vh"
`default_nettype none

// sequence overview
// idle: waits for start and decodes the method code once
// index methods: move to the chosen side until the index pulse
// current position: home captured at once, with no motion at all
// hard-stop methods: move under the homing clamp until blocked
// block: torque pinned at the clamp while speed is below threshold
// the block must hold for the whole detection time before it counts
// any lapse of either half of the condition restarts the timer
// hard-stop with index: reverse, restore the prior clamp, then index
// decel: motion command dropped, ramp at the homing rate
// done: one cycle with busy low before idle takes a new start
// status flags other than busy and the home_set pulse stay up until the next accepted start
// reserved and unknown codes raise the method error flag only
//
// limitations
// start is ignored anywhere but idle, including the done cycle
// the method code is read only in the cycle that start is taken
// the host must keep the detection inputs steady during a run
// a detection time of zero behaves as one sample
//
// trade-offs
// the torque test is at-or-above, so a loop that overshoots the
// clamp by a count still reads as saturated
// rest means zero measured speed; a noisy speed estimate that never
// reads zero will hold the sequencer in decel
// the prior clamp input is read again at each restore, so a restore after the
// block uses the value the host holds at that moment, not the value from before homing
//
module hbis_homing_seq #(
  parameter TW = 16,
  parameter VW = 16,
  parameter PW = 32
) (
  // clock and reset
  input  wire            clk,
  input  wire            resetn,
  // host command and configuration
  input  wire            start,
  input  wire [7:0]      method,
  input  wire [TW-1:0]   home_torque_limit,
  input  wire [TW-1:0]   prior_torque_limit,
  input  wire [VW-1:0]   detect_velocity,
  input  wire [31:0]     detect_cycles,
  input  wire [31:0]     homing_accel,
  // motor feedback
  input  wire [TW-1:0]   torque_abs,
  input  wire [VW-1:0]   speed_abs,
  input  wire            index_pulse,
  input  wire [PW-1:0]   position,
  // motion commands
  output reg             move_en,
  output reg             move_dir_pos,
  output reg  [TW-1:0]   torque_limit,
  output reg             decel_en,
  output reg  [31:0]     decel_rate,
  // status
  output reg             busy,
  output reg             home_attained,
  output reg             target_reached,
  output reg             method_error,
  output reg             home_set,
  output reg  [PW-1:0]   home_position
);

  // sequencer state, block timer and the reverse-search choice
  reg [2:0]  state;
  reg [31:0] blk_cnt;
  reg        blk_then_index;

  // block condition: torque saturated against clamp and speed below threshold
  wire blk_cond = (torque_abs >= torque_limit) &&
                  (speed_abs < detect_velocity);
  // count 1..detect_cycles; zero or one cycle both mean one sample
  wire blk_done = blk_cond && (blk_cnt + 32'h00000001 >= detect_cycles);

  // decode of block methods, used in one place: the start decode
  function is_blk;
    input [7:0] m;
    begin
      is_blk = (m == `HBIS_M_BLK_NEG) || (m == `HBIS_M_BLK_POS) ||
               (m == `HBIS_M_BLKI_NEG) || (m == `HBIS_M_BLKI_POS);
    end
  endfunction

  // hard-stop methods that search in the positive direction
  function is_blk_pos;
    input [7:0] m;
    begin
      is_blk_pos = (m == `HBIS_M_BLK_POS) || (m == `HBIS_M_BLKI_POS);
    end
  endfunction

  // hard-stop methods that end with a reverse index search
  function is_blk_idx;
    input [7:0] m;
    begin
      is_blk_idx = (m == `HBIS_M_BLKI_NEG) || (m == `HBIS_M_BLKI_POS);
    end
  endfunction

  // main sequencer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // every output low while reset is held
      state          <= `HBIS_ST_IDLE;
      blk_cnt        <= 32'h00000000;
      blk_then_index <= 1'b0;
      move_en        <= 1'b0;
      move_dir_pos   <= 1'b0;
      torque_limit   <= {TW{1'b0}};
      decel_en       <= 1'b0;
      decel_rate     <= 32'h00000000;
      busy           <= 1'b0;
      home_attained  <= 1'b0;
      target_reached <= 1'b0;
      method_error   <= 1'b0;
      home_set       <= 1'b0;
      home_position  <= {PW{1'b0}};
    end else begin
      // home_set is a one-cycle pulse
      home_set <= 1'b0;
      case (state)
        `HBIS_ST_IDLE: begin
          // follow the prior clamp so the clamp output is current while idle
          torque_limit <= prior_torque_limit;
          if (start) begin
            home_attained  <= 1'b0;
            target_reached <= 1'b0;
            method_error   <= 1'b0;
            blk_cnt        <= 32'h00000000;
            case (method)
              `HBIS_M_IDX_NEG, `HBIS_M_IDX_POS: begin
                move_en      <= 1'b1;
                move_dir_pos <= (method == `HBIS_M_IDX_POS);
                busy         <= 1'b1;
                state        <= `HBIS_ST_INDEX;
              end
              `HBIS_M_CURRENT: begin
                // no motion: already at rest, so both flags at once
                home_position  <= position;
                home_set       <= 1'b1;
                home_attained  <= 1'b1;
                target_reached <= 1'b1;
                state          <= `HBIS_ST_DONE;
              end
              default: begin
                if (is_blk(method)) begin
                  move_en        <= 1'b1;
                  // -1 and -3 negative, -2 and -4 positive
                  move_dir_pos   <= is_blk_pos(method);
                  torque_limit   <= home_torque_limit;
                  blk_then_index <= is_blk_idx(method);
                  busy           <= 1'b1;
                  state          <= `HBIS_ST_BLOCK;
                end else begin
                  // reserved 31/32 and unsupported codes: flag only
                  method_error <= 1'b1;
                end
              end
            endcase
          end
        end
        `HBIS_ST_BLOCK: begin
          // any lapse clears the timer, so only an unbroken run counts
          if (!blk_cond) begin
            blk_cnt <= 32'h00000000;
          end else if (!blk_done) begin
            blk_cnt <= blk_cnt + 32'h00000001;
          end else if (blk_then_index) begin
            // reverse and drop the homing clamp for the index search
            blk_cnt      <= 32'h00000000;
            move_dir_pos <= ~move_dir_pos;
            torque_limit <= prior_torque_limit;
            state        <= `HBIS_ST_INDEX;
          end else begin
            home_position <= position;
            home_set      <= 1'b1;
            home_attained <= 1'b1;
            move_en       <= 1'b0;
            decel_en      <= 1'b1;
            decel_rate    <= homing_accel;
            torque_limit  <= prior_torque_limit;
            state         <= `HBIS_ST_DECEL;
          end
        end
        `HBIS_ST_INDEX: begin
          // first index met in the search direction sets home
          if (index_pulse) begin
            home_position <= position;
            home_set      <= 1'b1;
            home_attained <= 1'b1;
            move_en       <= 1'b0;
            decel_en      <= 1'b1;
            decel_rate    <= homing_accel;
            state         <= `HBIS_ST_DECEL;
          end
        end
        `HBIS_ST_DECEL: begin
          // rest means zero measured speed, not merely slow
          if (speed_abs == {VW{1'b0}}) begin
            decel_en       <= 1'b0;
            target_reached <= 1'b1;
            busy           <= 1'b0;
            state          <= `HBIS_ST_DONE;
          end
        end
        `HBIS_ST_DONE: begin
          // one quiet cycle so a start held high for two cycles is not taken twice
          busy  <= 1'b0;
          state <= `HBIS_ST_IDLE;
        end
        default: begin
          // unused state code: recover to idle
          state <= `HBIS_ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== hbis_defs.vh
// constants for the homing block and index sequencer
// Function
// - methods 31 and 32 reserved, no motion
// - 33 negative, 34 positive, home at index
// - method 35 takes present position as home
// - method -1 moves negative, torque clamped
// - block: torque at limit, slow, for time
// - methods -1/-2 home attained on block
// - -3: block negative, reverse, home at index
// - -4: block positive, reverse, home at index
// - clamp only toward block, restore afterwards
// - home attained sets flag, homing decel
// - target reached only once motor at rest
`ifndef HBIS_DEFS_VH
`define HBIS_DEFS_VH
`define HBIS_M_RES1      8'h1F
`define HBIS_M_RES2      8'h20
`define HBIS_M_IDX_NEG   8'h21
`define HBIS_M_IDX_POS   8'h22
`define HBIS_M_CURRENT   8'h23
`define HBIS_M_BLK_NEG   8'hFF
`define HBIS_M_BLK_POS   8'hFE
`define HBIS_M_BLKI_NEG  8'hFD
`define HBIS_M_BLKI_POS  8'hFC
`define HBIS_ST_IDLE     3'h0
`define HBIS_ST_BLOCK    3'h1
`define HBIS_ST_INDEX    3'h2
`define HBIS_ST_DECEL    3'h3
`define HBIS_ST_DONE     3'h4
`define HBIS_DET_W       32
`endif

// ===== hbis_motor.sv
// motor model: torque, speed, index and position feedback
`default_nettype none
module hbis_motor (
  input  wire logic        clk, resetn, move_en, move_dir_pos, wall, wall_pos,
  input  wire logic [15:0] torque_limit,
  output logic      [15:0] torque_abs, speed_abs,
  output logic             index_pulse,
  output logic      [31:0] position
);
  timeunit 1ns;
  timeprecision 1ps;
  logic blk;
  // wall only stops motion heading toward it
  assign blk = wall && move_en && (move_dir_pos == wall_pos);
  assign torque_abs = blk ? torque_limit : 16'h0004;
  // index line is pulled low while stopped or blocked
  assign index_pulse = move_en && !blk && (position[2:0] == 3'h0);
  // free run at fixed speed, otherwise coast down one step a cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      speed_abs <= 16'h0000;
      position  <= 32'h0000_0000;
    end else begin
      if (move_en && !blk) speed_abs <= 16'h0010;
      else if (speed_abs != 16'h0000) speed_abs <= speed_abs - 16'h0001;
      if (move_en) position <= move_dir_pos ? position + 32'h1 : position - 32'h1;
    end
  end
endmodule
`default_nettype wire

// ===== hbis_sva.sv
// checker for the homing sequencer ports
`default_nettype none
module hbis_sva (
  input wire logic        clk, resetn, start, index_pulse, move_en, move_dir_pos,
  input wire logic        decel_en, busy, home_attained, target_reached,
  input wire logic        method_error, home_set,
  input wire logic [7:0]  method,
  input wire logic [15:0] home_torque_limit, prior_torque_limit, torque_limit,
  input wire logic [15:0] detect_velocity, torque_abs, speed_abs,
  input wire logic [31:0] detect_cycles, homing_accel, decel_rate,
  input wire logic [31:0] position, home_position
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [31:0] cnt;
  logic        take;
  assign take = start && !busy;
  // consecutive cycles of the block condition, zeroed on any lapse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cnt <= 32'h0;
    else cnt <= (move_en && torque_abs >= torque_limit &&
                 speed_abs < detect_velocity) ? cnt + 32'h1 : 32'h0;
  end
  AST_RESERVED: assert property (take && (method == 8'h1F ||
    method == 8'h20)
    |=> method_error && !move_en && !home_attained) else $error("reserved");
  AST_HERE: assert property (take && method == 8'h23 |=> home_set &&
    !move_en && target_reached && home_position == $past(position))
    else $error("current position home");
  AST_DIR: assert property (take && (method[7:2] == 6'h3F ||
    method == 8'h21 || method == 8'h22) |=> move_en &&
    move_dir_pos == !$past(method[0])) else $error("search direction");
  AST_CLAMP: assert property (take && method[7:2] == 6'h3F
    |=> torque_limit == $past(home_torque_limit)) else $error("clamp");
  AST_REVERSE: assert property (busy && move_en && $past(move_en) &&
    $changed(move_dir_pos) |-> torque_limit == prior_torque_limit &&
    cnt >= detect_cycles) else $error("reverse");
  AST_BLOCK: assert property ($rose(home_attained) &&
    method[7:1] == 7'h7F |-> cnt >= detect_cycles) else $error("block");
  AST_INDEX: assert property (busy && move_en && index_pulse &&
    torque_limit == prior_torque_limit |=> home_attained && home_set &&
    home_position == $past(position)) else $error("index home");
  AST_DECEL: assert property ($rose(home_attained) && method != 8'h23
    |-> decel_en && !move_en && decel_rate == homing_accel)
    else $error("decel");
  AST_REST: assert property ($rose(target_reached) && method != 8'h23
    |-> $past(speed_abs) == 16'h0 && !busy) else $error("rest");
  cover property ($rose(home_attained));
  cover property (busy && $changed(move_dir_pos));
  cover property ($rose(method_error));
endmodule
`default_nettype wire

// ===== hbis_homing_seq_test.sv
// testbench for the homing sequencer
`default_nettype none
module hbis_homing_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, start, index_pulse, move_en, move_dir_pos, wall;
  logic        wall_pos, decel_en, busy, home_attained, target_reached;
  logic        method_error, home_set, last_dir, done_q;
  logic [7:0]  method;
  logic [15:0] home_torque_limit, prior_torque_limit, torque_limit;
  logic [15:0] detect_velocity, torque_abs, speed_abs;
  logic [31:0] detect_cycles, homing_accel, decel_rate, position, home_position;
  logic [1:0]  q[$];
  logic [7:0]  ms[11] = '{8'h21, 8'h22, 8'h23, 8'hFF, 8'hFE, 8'hFD, 8'hFC,
                          8'h1F, 8'h20, 8'h24, 8'hFB};
  int          fails, n_tests, cyc;
  hbis_homing_seq i_hbis_homing_seq (.*);
  hbis_motor i_hbis_motor (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish;
    if (q.size() != 0) fails++;
    $display("checks %0d errors %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one homing run; the note holds error flag and final direction
  task automatic run(input logic [7:0] m);
    int k;
    logic e;
    @(posedge clk);
    #1;
    e = !(m inside {8'h21, 8'h22, 8'h23, [8'hFC:8'hFF]});
    q.push_back({e, e ? 1'b0 : (m[7] && !m[1]) ? m[0] : !m[0]});
    {method, start, wall, wall_pos} = {m, 1'b1, m[7], !m[0]};
    home_torque_limit = 16'($urandom);
    prior_torque_limit = ~home_torque_limit;
    homing_accel = $urandom;
    @(posedge clk);
    #1 start = 1'b0;
    k = 0;
    // drop the wall once so the detection count must restart
    do begin
      @(posedge clk);
      #1 k++;
      wall = m[7] && (k != 3);
    end while (!((home_attained | method_error) && !busy) && k < 300);
    if (k >= 300) fails++;
    wall = 1'b0;
    @(posedge clk);
  endtask
  // compare each completion against the oldest note
  always @(posedge clk) begin
    // a taken start re-arms the detector; error flags may stay high
    done_q <= (home_attained | method_error) && !start;
    last_dir <= start ? 1'b0 : move_en ? move_dir_pos : last_dir;
    if ((home_attained | method_error) && !done_q) begin
      n_tests++;
      if (q.size() == 0 || {method_error, last_dir} !== q[0]) begin
        fails++;
        $display("Error %0t: result mismatch", $time);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
    if (++cyc == 8000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    {resetn, start, wall, wall_pos, method, homing_accel} = '0;
    {home_torque_limit, prior_torque_limit} = '0;
    {detect_velocity, detect_cycles} = {16'h0008, 32'h4};
    void'($urandom(32'h936276B3));
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    foreach (ms[i]) run(ms[i]);
    tally_and_finish();
  end
endmodule
bind hbis_homing_seq hbis_sva i_hbis_sva (.*);
`default_nettype wire
